// ==== verilog/nabu_pkg.sv ====
// Package of opcodes, types and constants for the nibble ALU and branch unit
package nabu_pkg;

    localparam int NABU_PC_W = 11;
    localparam int NABU_RAM_AW = 7;
    localparam logic [NABU_PC_W-1:0] NABU_PC_RESET = 11'h000;
    localparam logic [3:0] NABU_ACC_RESET = 4'h0;
    localparam logic [NABU_RAM_AW-1:0] NABU_PAGE_STRIDE = 7'h10;
    localparam int NABU_PAGE_LSB = 0;
    localparam int NABU_PAGE_W = 3;

    typedef enum logic [4:0]
    {
        NABU_NOP,
        NABU_ADD,
        NABU_ADC,
        NABU_ADU,
        NABU_SUB,
        NABU_SBC,
        NABU_AND,
        NABU_OR,
        NABU_XOR,
        NABU_JMP,
        NABU_JBIT,
        NABU_JZ,
        NABU_JNZ,
        NABU_JC,
        NABU_JNC,
        NABU_DECREMENT_SKIP_IF_ZERO,
        NABU_DECREMENT_SKIP_IF_NONZERO
    } nabu_op_e;

    // One instruction as issued by the sequencer
    typedef struct packed
    {
        logic valid;
        nabu_op_e op;
        logic use_wr;
        logic use_imm;
        logic write_back;
        logic [1:0] bit_sel;
        logic [3:0] imm;
        logic [NABU_PC_W-1:0] target;
    } nabu_instr_s;

    // Results to RAM / working register / sequencer
    typedef struct packed
    {
        logic [3:0] result_nibble_reg;
        logic carry_flag;
        logic zero_flag;
        logic wr_en;
        logic wr_to_wreg;
        logic [3:0] wr_data;
        logic pc_load;
        logic [NABU_PC_W-1:0] pc_target;
        logic skip;
        logic [NABU_RAM_AW-1:0] ind_addr;
    } nabu_state_s;

endpackage : nabu_pkg

// ==== verilog/nabu_core.sv ====
// Nibble ALU and branch unit datapath
`timescale 1ns/1ns
module nabu_core
    import nabu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction and operands
    input wire nabu_instr_s instr,
    input wire logic [3:0] mem_operand,
    input wire logic [3:0] wreg_operand,
    input wire logic [3:0] page_reg,
    input wire logic [3:0] ind_operand,
    // Results
    output nabu_state_s st
);

    nabu_state_s state_q;
    nabu_state_s state_d;

    always_comb
    begin
        logic [3:0] a;
        logic [3:0] b;
        logic [4:0] sum;
        logic cin;
        a = 4'h0;
        b = 4'h0;
        sum = 5'h00;
        cin = 1'b0;
        state_d = state_q;
        state_d.wr_en = 1'b0;
        state_d.pc_load = 1'b0;
        state_d.skip = 1'b0;
        state_d.wr_to_wreg = instr.use_wr;
        state_d.pc_target = instr.target;
        // Page offset computed every cycle; the RAM mux picks it when needed
        state_d.ind_addr = NABU_RAM_AW'({page_reg[NABU_PAGE_LSB +: NABU_PAGE_W]} * NABU_PAGE_STRIDE)
            + NABU_RAM_AW'(ind_operand);
        a = instr.use_wr ? wreg_operand : mem_operand;
        b = instr.use_imm ? instr.imm : state_q.result_nibble_reg;
        cin = state_q.carry_flag;
        if (instr.valid)
        begin
            case (instr.op)
                NABU_ADD, NABU_ADC, NABU_ADU:
                begin
                    sum = {1'b0, a} + {1'b0, b} + {4'h0, (instr.op == NABU_ADC) & cin};
                    state_d.result_nibble_reg = sum[3:0];
                    state_d.zero_flag = (sum[3:0] == 4'h0);
                    if (instr.op != NABU_ADU)
                        state_d.carry_flag = sum[4];
                    // Otherwise carry kept
                    state_d.wr_en = instr.write_back;
                    state_d.wr_data = sum[3:0];
                end
                NABU_SUB, NABU_SBC:
                begin
                    // Carry set means no borrow occurred
                    sum = {1'b0, a} - {1'b0, b} - {4'h0, (instr.op == NABU_SBC) & cin};
                    state_d.result_nibble_reg = sum[3:0];
                    state_d.zero_flag = (sum[3:0] == 4'h0);
                    state_d.carry_flag = ~sum[4];
                    state_d.wr_en = instr.write_back;
                    state_d.wr_data = sum[3:0];
                end
                NABU_AND, NABU_OR, NABU_XOR:
                begin
                    if (instr.op == NABU_AND)
                        sum[3:0] = a & b;
                    else if (instr.op == NABU_OR)
                        sum[3:0] = a | b;
                    else
                        sum[3:0] = a ^ b;
                    state_d.result_nibble_reg = sum[3:0];
                    state_d.zero_flag = (sum[3:0] == 4'h0);
                    state_d.wr_en = instr.write_back;
                    state_d.wr_data = sum[3:0];
                end
                NABU_JMP:
                    state_d.pc_load = 1'b1;
                NABU_JBIT:
                    state_d.pc_load = state_q.result_nibble_reg[instr.bit_sel];
                NABU_JZ:
                    state_d.pc_load = (state_q.result_nibble_reg == 4'h0);
                NABU_JNZ:
                    state_d.pc_load = (state_q.result_nibble_reg != 4'h0);
                NABU_JC:
                    state_d.pc_load = state_q.carry_flag;
                NABU_JNC:
                    state_d.pc_load = ~state_q.carry_flag;
                NABU_DECREMENT_SKIP_IF_ZERO, NABU_DECREMENT_SKIP_IF_NONZERO:
                begin
                    sum = {1'b0, mem_operand} - 5'h01;
                    state_d.result_nibble_reg = sum[3:0];
                    state_d.zero_flag = (sum[3:0] == 4'h0);
                    state_d.carry_flag = ~sum[4];
                    state_d.wr_en = 1'b1;
                    state_d.wr_to_wreg = 1'b0;
                    state_d.wr_data = sum[3:0];
                    state_d.skip = (instr.op == NABU_DECREMENT_SKIP_IF_ZERO) ? (sum[3:0] == 4'h0) : (sum[3:0] != 4'h0);
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= '0;
            state_q.result_nibble_reg <= NABU_ACC_RESET;
            state_q.pc_target <= NABU_PC_RESET;
        end
        else
            state_q <= state_d;
    end

    assign st = state_q;

    AST_ADC_SUM: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_ADC |=> {st.carry_flag, st.result_nibble_reg} ==
        5'({1'b0, $past(instr.use_wr) ? $past(wreg_operand) : $past(mem_operand)}
        + {1'b0, $past(instr.use_imm) ? $past(instr.imm) : $past(st.result_nibble_reg)}
        + {4'h0, $past(st.carry_flag)}))
        else $error("Add with carry mismatch");

    AST_SUB_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && (instr.op == NABU_SUB || instr.op == NABU_SBC) |=>
        st.zero_flag == (st.result_nibble_reg == 4'h0))
        else $error("Subtract zero flag wrong");

    AST_WB: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op inside {NABU_ADD, NABU_SUB, NABU_AND} |=>
        st.wr_en == $past(instr.write_back) && (!st.wr_en || st.wr_data == st.result_nibble_reg))
        else $error("Write-back mismatch");

    AST_JBIT: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JBIT |=>
        st.pc_load == $past(st.result_nibble_reg[instr.bit_sel]) && st.pc_target == $past(instr.target))
        else $error("Bit jump wrong");

    AST_JZ: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JZ |=> st.pc_load == ($past(st.result_nibble_reg) == 4'h0))
        else $error("Jump on zero wrong");

    AST_JNZ: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JNZ |=> st.pc_load == ($past(st.result_nibble_reg) != 4'h0))
        else $error("Jump on nonzero wrong");

    AST_JC: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JC |=> st.pc_load == $past(st.carry_flag))
        else $error("Jump on carry wrong");

    AST_JNC: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JNC |=> st.pc_load == !$past(st.carry_flag))
        else $error("Jump on no carry wrong");

    AST_DSK: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_DECREMENT_SKIP_IF_ZERO |=> st.wr_en && st.wr_data == $past(mem_operand) - 4'h1
        && st.skip == (st.wr_data == 4'h0))
        else $error("Decrement skip wrong");

    AST_IND: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> st.ind_addr == {$past(page_reg[2:0]), $past(ind_operand)})
        else $error("Indirect address wrong");

    AST_ADU: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_ADU |=> $stable(st.carry_flag))
        else $error("Unsigned add touched carry");

    AST_LOGIC: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_XOR |=> $stable(st.carry_flag) && st.zero_flag == (st.result_nibble_reg == 4'h0))
        else $error("Logic op flags wrong");

    // Operand picks mirrored for the checks below
    logic [3:0] chk_a;
    logic [3:0] chk_b;
    assign chk_a = instr.use_wr ? wreg_operand : mem_operand;
    assign chk_b = instr.use_imm ? instr.imm : st.result_nibble_reg;

    // Named issue steps; each check pairs one with the answer an edge later
    sequence seq_issue_alu;
        instr.valid && instr.op inside {NABU_ADD, NABU_ADC, NABU_SUB, NABU_SBC, NABU_AND, NABU_OR, NABU_XOR};
    endsequence

    sequence seq_issue_idle;
        !instr.valid || instr.op == NABU_NOP;
    endsequence

    sequence seq_issue_jump;
        instr.valid && instr.op inside {NABU_JMP, NABU_JBIT, NABU_JZ, NABU_JNZ, NABU_JC, NABU_JNC};
    endsequence

    sequence seq_issue_dsk;
        instr.valid && instr.op inside {NABU_DECREMENT_SKIP_IF_ZERO, NABU_DECREMENT_SKIP_IF_NONZERO};
    endsequence

    AST_ADD_SUM: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_ADD |=>
        {st.carry_flag, st.result_nibble_reg} == 5'({1'b0, $past(chk_a)} + {1'b0, $past(chk_b)}))
        else $error("Add sum wrong");

    AST_SUB_DIFF: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_SUB |=>
        st.result_nibble_reg == 4'($past(chk_a) - $past(chk_b)) && st.carry_flag == ($past(chk_a) >= $past(chk_b)))
        else $error("Subtract difference wrong");

    AST_SBC_DIFF: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_SBC |=>
        st.result_nibble_reg == 4'($past(chk_a) - $past(chk_b) - {3'h0, $past(st.carry_flag)})
        && st.carry_flag == ({1'b0, $past(chk_a)} >= {1'b0, $past(chk_b)} + {4'h0, $past(st.carry_flag)}))
        else $error("Subtract with borrow wrong");

    AST_WB_DATA: assert property (@(posedge clk) disable iff (!resetn)
        seq_issue_alu |=> st.wr_en == $past(instr.write_back) && st.wr_to_wreg == $past(instr.use_wr)
        && (!st.wr_en || st.wr_data == st.result_nibble_reg))
        else $error("Write-back target wrong");

    // Nothing issued must leave result, flags and pulses quiet
    AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        seq_issue_idle |=> $stable(st.result_nibble_reg) && $stable(st.carry_flag) && $stable(st.zero_flag)
        && !st.wr_en && !st.pc_load && !st.skip)
        else $error("Idle cycle changed state");

    AST_JBIT_FALL: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JBIT && !st.result_nibble_reg[instr.bit_sel] |=>
        !st.pc_load)
        else $error("Bit jump taken on zero bit");

    // Branches only steer the sequencer; datapath state is left alone
    AST_JUMP_KEEPS: assert property (@(posedge clk) disable iff (!resetn)
        seq_issue_jump |=> $stable(st.result_nibble_reg) && $stable(st.carry_flag) && $stable(st.zero_flag)
        && !st.wr_en && !st.skip)
        else $error("Branch disturbed datapath");

    AST_JZ_TARGET: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JZ && st.result_nibble_reg == 4'h0 |=>
        st.pc_load && st.pc_target == $past(instr.target))
        else $error("Jump on zero target wrong");

    AST_JNZ_FALL: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JNZ && st.result_nibble_reg == 4'h0 |=>
        !st.pc_load)
        else $error("Jump on nonzero did not fall through");

    AST_JC_TARGET: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JC && st.carry_flag |=>
        st.pc_load && st.pc_target == $past(instr.target))
        else $error("Jump on carry target wrong");

    AST_JNC_TARGET: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_JNC && !st.carry_flag |=>
        st.pc_load && st.pc_target == $past(instr.target))
        else $error("Jump on no carry target wrong");

    AST_DECREMENT_SKIP_IF_NONZERO: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_DECREMENT_SKIP_IF_NONZERO |=> st.wr_en && !st.wr_to_wreg
        && st.result_nibble_reg == $past(mem_operand) - 4'h1 && st.skip == (st.result_nibble_reg != 4'h0))
        else $error("Decrement skip on nonzero wrong");

    AST_DSK_FLAGS: assert property (@(posedge clk) disable iff (!resetn)
        seq_issue_dsk |=> st.carry_flag == ($past(mem_operand) != 4'h0)
        && st.zero_flag == (st.result_nibble_reg == 4'h0))
        else $error("Decrement flags wrong");

    // A skip pulse may only answer a decrement
    AST_SKIP_SRC: assert property (@(posedge clk) disable iff (!resetn)
        st.skip |-> $past(instr.valid) && $past(instr.op) inside {NABU_DECREMENT_SKIP_IF_ZERO, NABU_DECREMENT_SKIP_IF_NONZERO})
        else $error("Skip without decrement");

    AST_IND_PAGE: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> st.ind_addr[6:4] == $past(page_reg[2:0]) && st.ind_addr[3:0] == $past(ind_operand))
        else $error("Indirect page field wrong");

    AST_ADU_SUM: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_ADU |=> st.result_nibble_reg == 4'($past(chk_a) + $past(chk_b))
        && st.zero_flag == (st.result_nibble_reg == 4'h0))
        else $error("Unsigned add sum wrong");

    AST_AND_RES: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_AND |=>
        st.result_nibble_reg == ($past(chk_a) & $past(chk_b)) && $stable(st.carry_flag))
        else $error("And result wrong");

    AST_OR_RES: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_OR |=>
        st.result_nibble_reg == ($past(chk_a) | $past(chk_b)) && $stable(st.carry_flag))
        else $error("Or result wrong");

    AST_XOR_RES: assert property (@(posedge clk) disable iff (!resetn)
        instr.valid && instr.op == NABU_XOR |=>
        st.result_nibble_reg == ($past(chk_a) ^ $past(chk_b)) && $stable(st.carry_flag))
        else $error("Xor result wrong");

endmodule : nabu_core

// ==== dv/nabu_far_model.sv ====
// Far-side model: one RAM nibble and the working register
`timescale 1ns/1ns
module nabu_far_model
    import nabu_pkg::*;
(
    // Clock, reset, writes from the unit
    input wire logic clk,
    input wire logic resetn,
    input wire nabu_state_s st,
    // Bench reload of the RAM nibble
    input wire logic load,
    input wire logic [3:0] load_val,
    // Operands
    output logic [3:0] mem_operand,
    output logic [3:0] wreg_operand
);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_operand <= 4'h9;
            wreg_operand <= 4'h6;
        end
        else if (st.wr_en && st.wr_to_wreg)
            wreg_operand <= st.wr_data;
        else if (st.wr_en)
            mem_operand <= st.wr_data;
        else if (load)
            mem_operand <= load_val;
    end
endmodule : nabu_far_model

// ==== dv/nabu_core_bench.sv ====
// Self-checking bench for the nibble ALU and branch unit
`timescale 1ns/1ns
module nabu_core_bench;
    import nabu_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    nabu_instr_s instr = '0;
    logic [3:0] page_reg = 4'h0;
    logic [3:0] ind_operand = 4'h0;
    logic load = 1'b0;
    logic [3:0] load_val = 4'h0;
    logic [3:0] mem_operand;
    logic [3:0] wreg_operand;
    logic [31:0] rnd;
    nabu_state_s st;
    nabu_state_s ex = '0;
    int err_total = 0;
    int samples_checked = 0;
    logic [3:0] acc = 4'h0;
    logic cf = 1'b0;
    logic zf = 1'b0;
    always #5 clk = ~clk;
    nabu_core nabu_core_inst (.clk(clk), .resetn(resetn), .instr(instr), .mem_operand(mem_operand),
        .wreg_operand(wreg_operand), .page_reg(page_reg), .ind_operand(ind_operand), .st(st));
    nabu_far_model nabu_far_model_inst (.clk(clk), .resetn(resetn), .st(st), .load(load),
        .load_val(load_val), .mem_operand(mem_operand), .wreg_operand(wreg_operand));
    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // Reference: integers, flags chain from one op to the next
    task automatic predict();
        int a;
        int b;
        int r;
        logic alu;
        a = instr.use_wr ? int'(wreg_operand) : int'(mem_operand);
        b = instr.use_imm ? int'(instr.imm) : int'(acc);
        r = 0;
        alu = 1'b0;
        ex.pc_load = 1'b0;
        ex.skip = 1'b0;
        ex.ind_addr = 7'(int'(page_reg[2:0]) * 16 + int'(ind_operand));
        if (instr.valid)
            case (instr.op)
                NABU_ADD, NABU_ADC, NABU_ADU:
                begin
                    r = a + b + ((instr.op == NABU_ADC) ? int'(cf) : 0);
                    cf = (instr.op == NABU_ADU) ? cf : (r > 15);
                    alu = 1'b1;
                end
                NABU_SUB, NABU_SBC:
                begin
                    r = a - b - ((instr.op == NABU_SBC) ? int'(cf) : 0);
                    cf = (r >= 0);
                    alu = 1'b1;
                end
                NABU_AND, NABU_OR, NABU_XOR:
                begin
                    r = (instr.op == NABU_AND) ? (a & b) : (instr.op == NABU_OR) ? (a | b) : (a ^ b);
                    alu = 1'b1;
                end
                NABU_DECREMENT_SKIP_IF_ZERO, NABU_DECREMENT_SKIP_IF_NONZERO:
                begin
                    r = a - 1;
                    cf = (a != 0);
                    ex.skip = ((r & 15) == 0) == (instr.op == NABU_DECREMENT_SKIP_IF_ZERO);
                    alu = 1'b1;
                end
                NABU_JMP: ex.pc_load = 1'b1;
                NABU_JBIT: ex.pc_load = acc[instr.bit_sel];
                NABU_JZ: ex.pc_load = (acc == 4'h0);
                NABU_JNZ: ex.pc_load = (acc != 4'h0);
                NABU_JC: ex.pc_load = cf;
                NABU_JNC: ex.pc_load = !cf;
                default: alu = 1'b0;
            endcase
        if (alu)
        begin
            acc = 4'(r);
            zf = (acc == 4'h0);
        end
        ex.wr_en = alu && instr.write_back;
        ex.wr_to_wreg = instr.use_wr;
        ex.wr_data = acc;
        ex.pc_target = instr.target;
        ex.result_nibble_reg = acc;
        ex.carry_flag = cf;
        ex.zero_flag = zf;
    endtask : predict
    initial
    begin
        rnd = $urandom(89452);
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (600)
        begin
            @(posedge clk);
            #1;
            chk(st.result_nibble_reg === ex.result_nibble_reg, "result");
            chk(st.carry_flag === ex.carry_flag && st.zero_flag === ex.zero_flag, "flags");
            chk(st.wr_en === ex.wr_en && (!ex.wr_en || (st.wr_data === ex.wr_data
                && st.wr_to_wreg === ex.wr_to_wreg)), "write");
            chk(st.pc_load === ex.pc_load && (!ex.pc_load || st.pc_target === ex.pc_target), "jump");
            chk(st.skip === ex.skip, "skip");
            chk(st.ind_addr === ex.ind_addr, "indirect address");
            rnd = $urandom;
            instr = rnd[$bits(nabu_instr_s)-1:0];
            instr.valid = ($urandom_range(0, 7) != 0);
            instr.op = nabu_op_e'(5'($urandom_range(0, 16)));
            // Decrement always targets RAM
            if (instr.op == NABU_DECREMENT_SKIP_IF_ZERO || instr.op == NABU_DECREMENT_SKIP_IF_NONZERO)
                instr.use_wr = 1'b0;
            if (instr.op == NABU_DECREMENT_SKIP_IF_ZERO || instr.op == NABU_DECREMENT_SKIP_IF_NONZERO)
                instr.write_back = 1'b1;
            page_reg = 4'($urandom);
            ind_operand = 4'($urandom);
            load = ($urandom_range(0, 3) == 0);
            load_val = 4'($urandom_range(0, 15));
            predict();
        end
        conclude();
    end
    initial
    begin
        #50000;
        err_total++;
        conclude();
    end
endmodule : nabu_core_bench
